// file: logic/cpu_timing_pkg.sv
package cpu_timing_pkg;

  // Field widths of the decoded timing record, the program address and the opcode
  localparam int LEN_W = 2;
  localparam int CYC_W = 4;
  localparam int PC_W = 16;
  localparam int OPC_W = 8;
  localparam int FLG_W = 3;

  typedef logic [LEN_W-1:0] len_t;
  typedef logic [CYC_W-1:0] cyc_t;

  // Program bytes occupied by an instruction
  localparam len_t LEN_1 = 2'h1;
  localparam len_t LEN_2 = 2'h2;
  localparam len_t LEN_3 = 2'h3;

  // Execution lengths in system clock cycles
  localparam cyc_t CYC_1 = 4'h1;
  localparam cyc_t CYC_2 = 4'h2;
  localparam cyc_t CYC_3 = 4'h3;
  localparam cyc_t CYC_4 = 4'h4;
  localparam cyc_t CYC_5 = 4'h5;
  localparam cyc_t CYC_DIV = 4'h8;

  // Extra cycle a conditional branch spends when taken
  localparam cyc_t CYC_TAKEN_EXTRA = 4'h1;

  // Opcodes with special handling
  localparam logic [OPC_W-1:0] OPC_NOP = 8'h00;
  localparam logic [OPC_W-1:0] OPC_SPARE = 8'hA5;

  // Status flag effect mask: bit 2 carry, bit 1 aux carry, bit 0 overflow
  localparam int FLG_CY_BIT = 2;
  localparam int FLG_AC_BIT = 1;
  localparam int FLG_OV_BIT = 0;
  localparam logic [FLG_W-1:0] FLG_NONE = 3'h0;
  localparam logic [FLG_W-1:0] FLG_CY = 3'h4;
  localparam logic [FLG_W-1:0] FLG_CY_OV = 3'h5;
  localparam logic [FLG_W-1:0] FLG_ALL = 3'h7;

  // Operand addressing mode
  typedef enum logic [3:0] {
    MODE_IMPLIED,
    MODE_ACC,
    MODE_REG,
    MODE_DIRECT,
    MODE_INDIRECT,
    MODE_IMMED,
    MODE_DIR_DIR,
    MODE_DIR_IMM,
    MODE_BIT,
    MODE_REL,
    MODE_ABS11,
    MODE_ABS16,
    MODE_CODE,
    MODE_EXT8,
    MODE_EXT16,
    MODE_DATA_POINTER_16_IMM
  } mode_t;

  // Decoded timing record of one instruction
  typedef struct packed {
    len_t len;
    cyc_t cyc;
    cyc_t cyc_taken;
    mode_t mode;
    logic cond_br;
    logic rel_br;
    logic [FLG_W-1:0] flags;
  } dec_t;

  localparam logic [PC_W-1:0] PC_RESET = 16'h0000;

endpackage

// file: logic/exec_sequencer.sv
`timescale 1ns/1ps
module exec_sequencer
  import cpu_timing_pkg::*;
#(
  parameter int CNT_W = cpu_timing_pkg::CYC_W
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_b_i,
  // Start of an instruction and its cycle count
  input wire logic start_i,
  input wire logic [CNT_W-1:0] cycles_i,
  // Sequencing state
  output logic ready_o,
  output logic done_o
);

  // Cycles still to run after the current one
  logic [CNT_W-1:0] remain_r;
  logic [CNT_W-1:0] remain_nxt;
  logic last_nxt;

  // Zero counts are treated as one so the core never stalls forever
  always_comb begin
    remain_nxt = remain_r;
    last_nxt = 1'b1;
    if (start_i) begin
      if (cycles_i > CNT_W'(1)) begin
        remain_nxt = cycles_i - CNT_W'(1);
        last_nxt = 1'b0;
      end else begin
        remain_nxt = '0;
      end
    end else if (remain_r != '0) begin
      remain_nxt = remain_r - CNT_W'(1);
      last_nxt = (remain_r == CNT_W'(1));
    end
  end

  // Count plain clock cycles; no machine-cycle grouping
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      remain_r <= '0;
    end else begin
      remain_r <= remain_nxt;
    end
  end

  // Ready only once the full count has elapsed
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ready_o <= 1'b1;
    end else begin
      ready_o <= last_nxt;
    end
  end

  // Done pulses in the last cycle of each instruction
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      done_o <= 1'b0;
    end else if (start_i || remain_r != '0) begin
      done_o <= last_nxt;
    end else begin
      done_o <= 1'b0;
    end
  end

endmodule

// file: logic/cpu_instruction_cycle_timing.sv
`timescale 1ns/1ps
// Contract
// - Decode opcodes, modes, flags as classic set
// - Sequence in plain clock cycles only
// - Most instructions: cycles equal byte count
// - Untaken conditional branch one cycle shorter
// - ADD/ADDC/SUBB: register 1, others 2
// - ANL/ORL/XRL to A: register 1, others 2
// - Logic to direct: A 2/2, immediate 3/3
// - Accumulator clear/complement/rotate/swap: 1 byte, 1
// - Moves: direct/immediate 2, register 1, dual 3
// - Indirect internal memory moves take 2 cycles
// - Load data pointer immediate: 3 bytes, 3
// - Code byte reads: 1 byte, 3 cycles
// - External data moves: 1 byte, 3 cycles
// - Push and pop direct: 2 bytes, 2
// - Relative target: signed byte plus next address
// - Spare opcode behaves as no-operation
module cpu_instruction_cycle_timing (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_b_i,
  // Instruction issue from the fetch stage
  input wire logic issue_valid_i,
  input wire logic [7:0] issue_opcode_i,
  input wire logic [15:0] issue_pc_i,
  input wire logic [7:0] issue_rel_i,
  input wire logic branch_cond_i,
  // Issue handshake and sequencing
  output logic issue_ready_o,
  output logic exec_done_o,
  // Decoded record and flow result, held until the next issue
  output cpu_timing_pkg::dec_t decode_o,
  output logic branch_taken_o,
  output logic [15:0] next_pc_o
);
  import cpu_timing_pkg::*;

  // Combinational decode of the issued opcode
  dec_t dec;
  logic [3:0] hi;
  logic [3:0] lo;
  logic accept;
  logic taken;
  cyc_t run_cycles;
  logic [PC_W-1:0] seq_pc;
  logic [PC_W-1:0] rel_pc;

  // Plain entry: taken and untaken lengths are the same
  function automatic dec_t ent(input len_t l, input cyc_t c, input mode_t m);
    dec_t r;
    r = '0;
    r.len = l;
    r.cyc = c;
    r.cyc_taken = c;
    r.mode = m;
    r.flags = FLG_NONE;
    return r;
  endfunction

  // Conditional relative branch: one more cycle when taken
  function automatic dec_t jrel(input len_t l, input cyc_t c, input mode_t m);
    dec_t r;
    r = ent(l, c, m);
    r.cond_br = 1'b1;
    r.rel_br = 1'b1;
    r.cyc_taken = c + CYC_TAKEN_EXTRA;
    return r;
  endfunction

  // The opcode splits into an operation row (high nibble) and an
  // operand column (low nibble); the column alone fixes the operand
  // kind for most rows, which keeps the decode table compact.
  // Rows that break the pattern are listed explicitly below.
  assign hi = issue_opcode_i[7:4];
  assign lo = issue_opcode_i[3:0];

  // Opcode map decode; the table keeps classic encodings and flag effects
  // Column order of the checks matters: the working register column
  // (bit 3 set) is tested first, then the indirect pointer column,
  // and only then the mixed low columns.
  // Every path starts from a one-byte, one-cycle default, but every case has
  // a default of its own, so a gap in the table takes that column's entry.
  // Parity is not in the flag mask; it always follows the accumulator.
  always_comb begin
    dec = ent(LEN_1, CYC_1, MODE_IMPLIED);
    if (lo[3]) begin
      // Working register column
      case (hi)
        4'h2, 4'h3, 4'h9: begin
          dec = ent(LEN_1, CYC_1, MODE_REG);
          dec.flags = FLG_ALL;
        end
        4'h4, 4'h5, 4'h6: dec = ent(LEN_1, CYC_1, MODE_REG);
        4'h7, 4'h8, 4'hA: dec = ent(LEN_2, CYC_2, MODE_REG);
        4'hB: begin
          // Compare immediate to register and branch
          dec = jrel(LEN_3, CYC_3, MODE_REG);
          dec.flags = FLG_CY;
        end
        4'hD: dec = jrel(LEN_2, CYC_2, MODE_REG);
        4'hE, 4'hF: dec = ent(LEN_1, CYC_1, MODE_REG);
        default: dec = ent(LEN_1, CYC_1, MODE_REG);
      endcase
    end else if (lo[2:1] == 2'h3) begin
      // Indirect pointer register column
      case (hi)
        4'h2, 4'h3, 4'h9: begin
          dec = ent(LEN_1, CYC_2, MODE_INDIRECT);
          dec.flags = FLG_ALL;
        end
        4'h4, 4'h5, 4'h6: dec = ent(LEN_1, CYC_2, MODE_INDIRECT);
        4'h7, 4'h8, 4'hA: dec = ent(LEN_2, CYC_2, MODE_INDIRECT);
        4'hB: begin
          dec = jrel(LEN_3, CYC_4, MODE_INDIRECT);
          dec.flags = FLG_CY;
        end
        4'hE, 4'hF: dec = ent(LEN_1, CYC_2, MODE_INDIRECT);
        default: dec = ent(LEN_1, CYC_2, MODE_INDIRECT);
      endcase
    end else begin
      case (lo[2:0])
        3'h0: begin
          case (hi)
            4'h0: dec = ent(LEN_1, CYC_1, MODE_IMPLIED);
            4'h1, 4'h2, 4'h3: dec = jrel(LEN_3, CYC_3, MODE_BIT);
            4'h4, 4'h5, 4'h6, 4'h7: dec = jrel(LEN_2, CYC_2, MODE_REL);
            4'h8: begin
              // Short jump is always taken
              dec = ent(LEN_2, CYC_3, MODE_REL);
              dec.rel_br = 1'b1;
            end
            4'h9: dec = ent(LEN_3, CYC_3, MODE_DATA_POINTER_16_IMM);
            4'hA, 4'hB: begin
              dec = ent(LEN_2, CYC_2, MODE_BIT);
              dec.flags = FLG_CY;
            end
            4'hC, 4'hD: dec = ent(LEN_2, CYC_2, MODE_DIRECT);
            default: dec = ent(LEN_1, CYC_3, MODE_EXT16);
          endcase
        end
        3'h1: dec = ent(LEN_2, CYC_3, MODE_ABS11);
        3'h2: begin
          case (hi)
            4'h0, 4'h1: dec = ent(LEN_3, CYC_4, MODE_ABS16);
            4'h2, 4'h3: dec = ent(LEN_1, CYC_5, MODE_IMPLIED);
            4'h4, 4'h5, 4'h6: dec = ent(LEN_2, CYC_2, MODE_DIRECT);
            4'h7, 4'h8, 4'hA: begin
              dec = ent(LEN_2, CYC_2, MODE_BIT);
              dec.flags = FLG_CY;
            end
            4'hE, 4'hF: dec = ent(LEN_1, CYC_3, MODE_EXT8);
            default: dec = ent(LEN_2, CYC_2, MODE_BIT);
          endcase
        end
        3'h3: begin
          case (hi)
            4'h0, 4'h2: dec = ent(LEN_1, CYC_1, MODE_ACC);
            4'h1, 4'h3: begin
              dec = ent(LEN_1, CYC_1, MODE_ACC);
              dec.flags = FLG_CY;
            end
            4'h4, 4'h5, 4'h6: dec = ent(LEN_3, CYC_3, MODE_DIR_IMM);
            4'h7: dec = ent(LEN_1, CYC_3, MODE_CODE);
            4'h8, 4'h9: dec = ent(LEN_1, CYC_3, MODE_CODE);
            4'hA: dec = ent(LEN_1, CYC_1, MODE_IMPLIED);
            4'hB, 4'hC, 4'hD: begin
              dec = ent(LEN_1, CYC_1, MODE_IMPLIED);
              dec.flags = FLG_CY;
            end
            default: dec = ent(LEN_1, CYC_3, MODE_EXT8);
          endcase
        end
        3'h4: begin
          case (hi)
            4'h2, 4'h3, 4'h9: begin
              dec = ent(LEN_2, CYC_2, MODE_IMMED);
              dec.flags = FLG_ALL;
            end
            4'h4, 4'h5, 4'h6: dec = ent(LEN_2, CYC_2, MODE_IMMED);
            4'h7: dec = ent(LEN_2, CYC_2, MODE_IMMED);
            4'h8: begin
              // Divide clears carry and reports overflow
              dec = ent(LEN_1, CYC_DIV, MODE_ACC);
              dec.flags = FLG_CY_OV;
            end
            4'hA: begin
              dec = ent(LEN_1, CYC_4, MODE_ACC);
              dec.flags = FLG_CY_OV;
            end
            4'hB: begin
              dec = jrel(LEN_3, CYC_3, MODE_IMMED);
              dec.flags = FLG_CY;
            end
            4'hD: begin
              // Decimal adjust may set carry
              dec = ent(LEN_1, CYC_1, MODE_ACC);
              dec.flags = FLG_CY;
            end
            default: dec = ent(LEN_1, CYC_1, MODE_ACC);
          endcase
        end
        default: begin
          // Direct byte column
          case (hi)
            4'h2, 4'h3, 4'h9: begin
              dec = ent(LEN_2, CYC_2, MODE_DIRECT);
              dec.flags = FLG_ALL;
            end
            4'h4, 4'h5, 4'h6: dec = ent(LEN_2, CYC_2, MODE_DIRECT);
            4'h7: dec = ent(LEN_3, CYC_3, MODE_DIR_IMM);
            4'h8: dec = ent(LEN_3, CYC_3, MODE_DIR_DIR);
            4'hA: dec = ent(LEN_1, CYC_1, MODE_IMPLIED);
            4'hB: begin
              dec = jrel(LEN_3, CYC_3, MODE_DIRECT);
              dec.flags = FLG_CY;
            end
            4'hD: dec = jrel(LEN_3, CYC_3, MODE_DIRECT);
            4'hE, 4'hF: dec = ent(LEN_2, CYC_2, MODE_DIRECT);
            default: dec = ent(LEN_2, CYC_2, MODE_DIRECT);
          endcase
        end
      endcase
    end
  end

  // Issue is taken only while the sequencer is idle
  // A request held across busy cycles is simply ignored; nothing is
  // latched until ready returns, so the fetch stage may keep valid up.
  // Ready comes from a flip-flop, so this gate adds no long path
  // from the decode table into the fetch stage.
  assign accept = issue_valid_i & issue_ready_o;

  // Branch outcome: short jump always, conditionals on the datapath test
  // The condition must be valid in the issue cycle; a late condition
  // would give the wrong length, so the datapath resolves it early.
  assign taken = dec.rel_br & (~dec.cond_br | branch_cond_i);

  // Cycle count to run, lengthened by one for a taken conditional branch
  // Both counts sit in the record, so the choice is one small mux
  // rather than an adder in the issue path.
  assign run_cycles = taken ? dec.cyc_taken : dec.cyc;

  // Address of the following instruction and relative target
  // The displacement is sign extended and added to the address after
  // the branch; both sums wrap at the top of the 16-bit space.
  assign seq_pc = issue_pc_i + PC_W'(dec.len);
  assign rel_pc = seq_pc + {{8{issue_rel_i[7]}}, issue_rel_i};

  // Cycle sequencer; its ready gates the next issue
  // Counting lives in its own module so the decode table stays purely
  // combinational and the sequencing can be checked on its own.
  // Its outputs are registers, which keeps the top outputs clean.
  exec_sequencer #(
    .CNT_W(CYC_W)
  ) u_seq (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .start_i(accept),
    .cycles_i(run_cycles),
    .ready_o(issue_ready_o),
    .done_o(exec_done_o)
  );

  // Decoded record held for the datapath for the whole instruction
  // Holding it until the next issue lets the datapath read the mode
  // and flag mask in any cycle of a long instruction.
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      decode_o <= ent(LEN_1, CYC_1, MODE_IMPLIED);
    end else if (accept) begin
      decode_o <= dec;
    end
  end

  // Branch outcome, held with the record
  // Loaded on the same edge as the record so the two always agree,
  // even when a reset cuts an instruction short.
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      branch_taken_o <= 1'b0;
    end else if (accept) begin
      branch_taken_o <= taken;
    end
  end

  // Next program address; absolute jumps and returns are resolved
  // by the datapath, which overrides this sequential value
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      next_pc_o <= PC_RESET;
    end else if (accept) begin
      next_pc_o <= taken ? rel_pc : seq_pc;
    end
  end

endmodule

// file: dv/cpu_timing_checker.sv
`timescale 1ns/1ps
// Timing and record checks on the issue port of the decoder
module cpu_timing_checker (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_b_i,
  // Issue side
  input wire logic issue_valid_i,
  input wire logic [7:0] issue_opcode_i,
  input wire logic [15:0] issue_pc_i,
  input wire logic [7:0] issue_rel_i,
  input wire logic branch_cond_i,
  // Sequencing and decoded record
  input wire logic issue_ready_o,
  input wire logic exec_done_o,
  input wire cpu_timing_pkg::dec_t decode_o,
  input wire logic branch_taken_o,
  input wire logic [15:0] next_pc_o
);
  import cpu_timing_pkg::*;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  // An issue is taken on this edge
  logic acc;
  assign acc = issue_valid_i && issue_ready_o;

  busy_gate_a: assert property (acc |=> issue_ready_o ==
    (decode_o.cyc == CYC_1 && !branch_taken_o))
    else $error("ready wrong after issue");
  done_first_a: assert property (acc |=> exec_done_o == issue_ready_o)
    else $error("done and ready disagree");
  two_cycle_a: assert property (acc ##1
    (decode_o.cyc == CYC_2 && !branch_taken_o) |->
    !issue_ready_o ##1 (issue_ready_o && exec_done_o))
    else $error("two cycle timing wrong");
  three_cycle_a: assert property (acc ##1
    (decode_o.cyc == CYC_3 && !branch_taken_o) |->
    !issue_ready_o [*2] ##1 (issue_ready_o && exec_done_o))
    else $error("three cycle timing wrong");
  taken_ext_a: assert property (acc ##1 decode_o.cond_br |->
    decode_o.cyc_taken == decode_o.cyc + CYC_TAKEN_EXTRA)
    else $error("taken count not one longer");
  taken_flag_a: assert property (acc |=> branch_taken_o ==
    (decode_o.rel_br && (!decode_o.cond_br || $past(branch_cond_i))))
    else $error("taken flag wrong");
  rel_target_a: assert property (acc |=> next_pc_o ==
    $past(issue_pc_i) + 16'(decode_o.len) + (branch_taken_o ?
    {{8{$past(issue_rel_i[7])}}, $past(issue_rel_i)} : 16'h0000))
    else $error("next address wrong");
  spare_nop_a: assert property (acc && issue_opcode_i == OPC_SPARE |=>
    decode_o.len == LEN_1 && decode_o.cyc == CYC_1 && !decode_o.rel_br &&
    decode_o.mode == MODE_IMPLIED && decode_o.flags == FLG_NONE)
    else $error("spare opcode not a no-op");
  // Refused or absent issues must leave the record untouched
  hold_rec_a: assert property (!acc |=> $stable(decode_o) &&
    $stable(next_pc_o) && $stable(branch_taken_o))
    else $error("record changed without issue");

  cover property (acc && issue_opcode_i == OPC_SPARE);
  cover property (acc ##1 branch_taken_o);
  cover property (acc ##1 decode_o.cyc == CYC_3);
endmodule

bind cpu_instruction_cycle_timing cpu_timing_checker cpu_timing_checker_inst (
  .clock_i(clock_i), .rst_b_i(rst_b_i), .issue_valid_i(issue_valid_i),
  .issue_opcode_i(issue_opcode_i), .issue_pc_i(issue_pc_i),
  .issue_rel_i(issue_rel_i), .branch_cond_i(branch_cond_i),
  .issue_ready_o(issue_ready_o), .exec_done_o(exec_done_o),
  .decode_o(decode_o), .branch_taken_o(branch_taken_o),
  .next_pc_o(next_pc_o));

// file: dv/cpu_instruction_cycle_timing_tb.sv
`timescale 1ns/1ps
module cpu_instruction_cycle_timing_tb;
  import cpu_timing_pkg::*;
  // Drive, all changed at the falling edge
  logic clock_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic issue_valid_i = 1'b0;
  logic [7:0] issue_opcode_i = 8'h00;
  logic [15:0] issue_pc_i = 16'h0000;
  logic [7:0] issue_rel_i = 8'h00;
  logic branch_cond_i = 1'b0;
  // Observed outputs
  logic issue_ready_o, exec_done_o, branch_taken_o;
  dec_t decode_o;
  logic [15:0] next_pc_o;
  int err_total = 0;
  int n_tests = 0;
  // Starts near the top so the address wrap is exercised
  logic [15:0] pc_v = 16'hFFF8;

  cpu_instruction_cycle_timing cpu_instruction_cycle_timing_inst (
    .clock_i(clock_i), .rst_b_i(rst_b_i), .issue_valid_i(issue_valid_i),
    .issue_opcode_i(issue_opcode_i), .issue_pc_i(issue_pc_i),
    .issue_rel_i(issue_rel_i), .branch_cond_i(branch_cond_i),
    .issue_ready_o(issue_ready_o), .exec_done_o(exec_done_o),
    .decode_o(decode_o), .branch_taken_o(branch_taken_o),
    .next_pc_o(next_pc_o));

  initial forever #20 clock_i = ~clock_i;

  task automatic results();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // Issue one opcode at a falling edge with ready high; valid stays up,
  // so the busy cycles also show that a held request is refused
  task automatic run_op(input logic [7:0] op, input len_t l, input cyc_t c,
      input cyc_t x, input logic cnd, input logic tk, input logic [7:0] r);
    int n;
    logic [15:0] pc;
    pc = pc_v;
    issue_valid_i = 1'b1;
    issue_opcode_i = op;
    issue_pc_i = pc;
    issue_rel_i = r;
    branch_cond_i = cnd;
    @(negedge clock_i);
    chk(16'(decode_o.len), 16'(l));
    chk(16'(decode_o.cyc), 16'(c));
    chk(16'(branch_taken_o), 16'(tk));
    chk(next_pc_o, pc + 16'(l) + (tk ? {{8{r[7]}}, r} : 16'h0000));
    n = 1;
    while (exec_done_o !== 1'b1) begin
      if (n > 9) begin
        err_total++;
        results();
      end
      @(negedge clock_i);
      n++;
    end
    chk(16'(n), 16'(c + x));
    pc_v = pc + 16'(l);
  endtask

  // Entry: opcode byte, length nibble, cycle nibble
  task automatic run_tab(input logic [15:0] t[$]);
    foreach (t[i])
      run_op(t[i][15:8], t[i][5:4], t[i][3:0], 4'h0, 1'b0, 1'b0, 8'h00);
  endtask

  task automatic t_alu();
    run_tab('{16'h2811, 16'h2522, 16'h2612, 16'h2422, 16'h3811, 16'h3522,
      16'h3612, 16'h3422, 16'h9811, 16'h9522, 16'h9712, 16'h9422});
    chk(16'(decode_o.flags), 16'(FLG_ALL));
    run_tab('{16'hE411, 16'hF411, 16'h2311, 16'h3311, 16'h0311, 16'h1311,
      16'hC411});
    chk(16'(decode_o.flags), 16'(FLG_NONE));
    $display("alu timing done");
  endtask

  task automatic t_logic();
    run_tab('{16'h5811, 16'h5612, 16'h5522, 16'h5422, 16'h4811, 16'h4612,
      16'h4522, 16'h4422, 16'h6811, 16'h6612, 16'h6522, 16'h6422});
    run_tab('{16'h5222, 16'h5333, 16'h4222, 16'h4333, 16'h6222,
      16'h6333});
    $display("logic timing done");
  endtask

  task automatic t_move();
    run_tab('{16'hE811, 16'hE522, 16'h7422, 16'hF811, 16'hA822, 16'h8533,
      16'h7533});
    run_tab('{16'hE612, 16'hF612, 16'hA622, 16'h7622, 16'h8622});
    run_tab('{16'h9033});
    run_tab('{16'h9313, 16'h8313});
    run_tab('{16'hE213, 16'hF313, 16'hE013, 16'hF013});
    run_tab('{16'hC022, 16'hD022});
    $display("move timing done");
  endtask

  task automatic t_branch();
    run_op(8'h60, 2'h2, 4'h2, 4'h0, 1'b0, 1'b0, 8'hFE);
    run_op(8'h60, 2'h2, 4'h2, 4'h1, 1'b1, 1'b1, 8'hFE);
    run_op(8'h50, 2'h2, 4'h2, 4'h1, 1'b1, 1'b1, 8'h7F);
    run_op(8'h80, 2'h2, 4'h3, 4'h0, 1'b0, 1'b1, 8'h80);
    run_op(8'hB4, 2'h3, 4'h3, 4'h1, 1'b1, 1'b1, 8'h05);
    run_op(8'hB4, 2'h3, 4'h3, 4'h0, 1'b0, 1'b0, 8'h05);
    $display("branch timing done");
  endtask

  task automatic t_spare();
    run_tab('{16'hA511});
    chk(16'(decode_o.mode), 16'(MODE_IMPLIED));
    chk(16'(decode_o.flags), 16'(FLG_NONE));
    $display("spare opcode done");
  endtask

  // Reset lands in the first cycle of a three-cycle instruction
  task automatic t_reset();
    issue_valid_i = 1'b1;
    issue_opcode_i = 8'h90;
    @(negedge clock_i);
    issue_valid_i = 1'b0;
    rst_b_i = 1'b0;
    #5;
    chk(16'(issue_ready_o), 16'h0001);
    chk(16'(exec_done_o), 16'h0000);
    chk(16'(decode_o.cyc), 16'(CYC_1));
    chk(next_pc_o, PC_RESET);
    @(negedge clock_i);
    rst_b_i = 1'b1;
    pc_v = 16'h0100;
    $display("mid-run reset done");
  endtask

  initial begin
    repeat (12) @(negedge clock_i);
    rst_b_i = 1'b1;
    t_alu();
    t_logic();
    t_move();
    t_branch();
    t_spare();
    t_reset();
    t_spare();
    results();
  end
endmodule
